// ### hw/irq_front_pkg.sv
/*
 Constants, register map and state codes shared by the interrupt front end.
 Assumes a single 20 MHz clock domain and 32-bit classic Wishbone registers.
*/
package irq_front_pkg;

	// Register byte offsets
	localparam logic [7:0] ROUTE_A_OFS = 8'h00;
	localparam logic [7:0] ROUTE_B_OFS = 8'h04;
	localparam logic [7:0] ROUTE_C_OFS = 8'h08;
	localparam logic [7:0] ROUTE_D_OFS = 8'h0c;
	localparam logic [7:0] SIRQ_CTRL_OFS = 8'h10;
	localparam logic [7:0] SIRQ_STAT_OFS = 8'h14;

	// Route control fields
	localparam int ROUTE_DIS_BIT = 7;
	localparam logic [7:0] ROUTE_RST = 8'h80;
	localparam logic [15:0] ROUTE_OK_MASK = 16'hdef8;

	// Serial control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_EXT_LSB = 1;
	localparam int CTRL_QUIET_BIT = 4;
	localparam int CTRL_FRAMES_LSB = 8;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [2:0] CTRL_EXT_RST = 3'h3;
	localparam logic CTRL_QUIET_RST = 1'b0;
	localparam logic [5:0] CTRL_FRAMES_RST = 6'h15;

	// Serial timing in clocks
	localparam logic [2:0] START_EXT_MIN = 3'h3;
	localparam logic [2:0] STOP_QUIET_LEN = 3'h2;
	localparam logic [2:0] STOP_CONT_LEN = 3'h3;

	// Frame numbers
	localparam logic [5:0] FR_MGMT = 6'h03;
	localparam logic [5:0] FR_IRQ_FIRST = 6'h02;
	localparam logic [5:0] FR_IRQ_LAST = 6'h10;
	localparam logic [5:0] FR_PCI_FIRST = 6'h12;
	localparam logic [5:0] FR_PCI_LAST = 6'h15;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_START_LOW = 7'h02,
		ST_START_HIGH = 7'h04,
		ST_FRAME = 7'h08,
		ST_STOP_LOW = 7'h10,
		ST_STOP_HIGH = 7'h20,
		ST_GAP = 7'h40
	} sirq_state_e;

endpackage : irq_front_pkg

// ### hw/irq_line_sync.sv
/*
 Two-flop synchroniser for a group of asynchronous level inputs.
 Assumes the inputs change slowly compared with the clock.
*/
`timescale 1ns/100ps
module irq_line_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// First stage is read only by the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule : irq_line_sync

// ### hw/irq_route_mux.sv
/*
 Steering multiplexer: maps each active PCI interrupt onto one legacy input.
 Assumes active-high request levels and one 8-bit route control per line.
*/
`timescale 1ns/100ps
module irq_route_mux
	import irq_front_pkg::*;
#(
	parameter int LINES = 4
) (
	input wire logic [LINES-1:0] req_i,
	input wire logic [8*LINES-1:0] route_i,
	output logic [15:0] irq_o
);
	logic [15:0] part [LINES+1];

	assign part[0] = 16'h0000;

	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			logic [3:0] sel;
			logic ok;
			assign sel = route_i[8*g +: 4];
			// Disabled or unlisted targets leave the line unrouted
			assign ok = !route_i[8*g+ROUTE_DIS_BIT] && ROUTE_OK_MASK[sel]; // [RQ1] [RQ4] [RQ5] [RQ25]
			// Shared targets simply OR together
			assign part[g+1] = part[g] | ((ok && req_i[g]) ? (16'h0001 << sel) : 16'h0000); // [RQ3]
		end
	endgenerate

	assign irq_o = part[LINES];
endmodule : irq_route_mux

// ### hw/pci_irq_steering_serial_irq_host.sv
/*
 PCI interrupt steering and serial interrupt host, with a Wishbone slave.
 Assumes one 20 MHz clock, synchronous serial line input, external pull-up.
*/
// The Wishbone register port and the placing of the registers were chosen for this implementation.
// What this block does
// [RQ1] Steer four PCI lines to eleven legacy inputs
// [RQ2] Synchronise PCI lines before the multiplexer
// [RQ3] Several lines may share one input
// [RQ4] Route target from bits 0 to 3
// [RQ5] Bit 7 disables routing of line
// [RQ6] PCI lines active low, level sensitive
// [RQ7] Serial line open collector, pull low only
// [RQ8] Peripheral restarts stopped clock before signalling
// [RQ9] Quiet start pulse is one clock low
// [RQ10] Host extends start low 3 to 7 clocks
// [RQ11] Drive high one clock, then release
// [RQ12] Continuous mode: host originates 4-8 clock start
// [RQ13] Reset in continuous; quiet only via stop
// [RQ14] Frames: sample, recovery, turn-around phases
// [RQ15] Peripheral drives only in its sample phase
// [RQ16] Decode frame n at 2+3(n-1)
// [RQ17] Ignore frame one, channel check, unassigned
// [RQ18] Management frame asserts external management output
// [RQ19] Host never drives data frames
// [RQ20] Stop low 2 for quiet, 3 continuous
// [RQ21] Next start from second clock after stop
// [RQ22] OR serial interrupts with legacy inputs
// [RQ23] Level inputs pass without edge detection
// [RQ24] Stop right after last frame, default 21
// [RQ25] Invalid route target leaves line unrouted
`timescale 1ns/100ps
module pci_irq_steering_serial_irq_host
	import irq_front_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] pci_irq_lines_a_to_d_n_i,
	input wire logic [15:0] legacy_irq_i,
	input wire logic serial_irq_line_i,
	output logic serial_irq_line_o,
	output logic serial_irq_line_oe_o,
	output logic [15:0] irq_o,
	output logic external_mgmt_irq_out_n_o
);

	////////////////////////////////////////////////////////////////////////////
	// Registers and bus slave

	logic [7:0] route_reg [4];
	logic ctrl_en_reg;
	logic [2:0] ctrl_ext_reg;
	logic ctrl_quiet_reg;
	logic [5:0] ctrl_frames_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [15:0] ser_irq_reg;
	logic [3:0] ser_pci_reg;
	logic mgmt_reg;
	logic mgmt_n_reg;
	logic mode_quiet_reg;
	sirq_state_e state_reg;
	sirq_state_e state_next;

	logic req;
	logic wr;
	logic [31:0] rdat_next;

	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr = req && wb_we_i;

	always_comb begin
		rdat_next = 32'h0000_0000;
		case (wb_adr_i)
			ROUTE_A_OFS: rdat_next = {24'h00_0000, route_reg[0]};
			ROUTE_B_OFS: rdat_next = {24'h00_0000, route_reg[1]};
			ROUTE_C_OFS: rdat_next = {24'h00_0000, route_reg[2]};
			ROUTE_D_OFS: rdat_next = {24'h00_0000, route_reg[3]};
			SIRQ_CTRL_OFS: begin
				rdat_next[CTRL_EN_BIT] = ctrl_en_reg;
				rdat_next[CTRL_EXT_LSB +: 3] = ctrl_ext_reg;
				rdat_next[CTRL_QUIET_BIT] = ctrl_quiet_reg;
				rdat_next[CTRL_FRAMES_LSB +: 6] = ctrl_frames_reg;
			end
			SIRQ_STAT_OFS: rdat_next = {9'h000, state_reg != ST_IDLE, mode_quiet_reg, mgmt_reg,
				ser_pci_reg, ser_irq_reg};
			default: rdat_next = 32'h0000_0000;
		endcase
	end

	// One wait-free answer: ack the cycle after the request, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req && !wb_we_i) begin
				rdat_reg <= rdat_next;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_route
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					route_reg[g] <= ROUTE_RST;
				end else if (wr && wb_sel_i[0] && wb_adr_i == ROUTE_A_OFS + 8'(4 * g)) begin
					route_reg[g] <= wb_dat_i[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_en_reg <= CTRL_EN_RST;
			ctrl_ext_reg <= CTRL_EXT_RST;
			ctrl_quiet_reg <= CTRL_QUIET_RST;
			ctrl_frames_reg <= CTRL_FRAMES_RST;
		end else if (wr && wb_adr_i == SIRQ_CTRL_OFS) begin
			if (wb_sel_i[0]) begin
				ctrl_en_reg <= wb_dat_i[CTRL_EN_BIT];
				ctrl_ext_reg <= wb_dat_i[CTRL_EXT_LSB +: 3];
				ctrl_quiet_reg <= wb_dat_i[CTRL_QUIET_BIT];
			end
			if (wb_sel_i[1]) begin
				ctrl_frames_reg <= wb_dat_i[CTRL_FRAMES_LSB +: 6];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Steering

	logic [3:0] pci_sync_n;
	logic [15:0] steered;
	logic [31:0] route_flat;
	logic [15:0] irq_reg;

	irq_line_sync #(.W(4), .RST_VAL(4'hf)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(pci_irq_lines_a_to_d_n_i),
		.sync_o(pci_sync_n)
	); // [RQ2]

	assign route_flat = {route_reg[3], route_reg[2], route_reg[1], route_reg[0]};

	irq_route_mux #(.LINES(4)) u_mux (
		.req_i(~pci_sync_n | ser_pci_reg),
		.route_i(route_flat),
		.irq_o(steered)
	); // [RQ6]

	// Plain levels reach the controller, so level-mode inputs see no edge logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 16'h0000;
		end else begin
			irq_reg <= legacy_irq_i | ser_irq_reg | steered; // [RQ22] [RQ23] [RQ3]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial interrupt host

	logic [2:0] cnt_reg;
	logic [1:0] phase_reg;
	logic [5:0] frame_no_reg;
	logic stop_quiet_reg;
	logic oe_reg;
	logic out_reg;
	logic [2:0] ext_eff;
	logic [5:0] fn;
	logic sampling;

	// Short extension values are raised to the legal minimum
	assign ext_eff = (ctrl_ext_reg < START_EXT_MIN) ? START_EXT_MIN : ctrl_ext_reg;
	assign fn = frame_no_reg + 6'h01;
	assign sampling = state_reg == ST_FRAME && phase_reg == 2'h0;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ctrl_en_reg && (!mode_quiet_reg || !serial_irq_line_i)) begin
					state_next = ST_START_LOW; // [RQ12] [RQ10]
				end
			end
			ST_START_LOW: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_START_HIGH;
				end
			end
			ST_START_HIGH: state_next = ST_FRAME;
			ST_FRAME: begin
				if (phase_reg == 2'h2 && frame_no_reg == ctrl_frames_reg) begin
					state_next = ST_STOP_LOW; // [RQ24]
				end
			end
			ST_STOP_LOW: begin
				if (cnt_reg == 3'h0) begin
					state_next = ST_STOP_HIGH;
				end
			end
			ST_STOP_HIGH: state_next = ST_GAP;
			ST_GAP: state_next = ST_IDLE; // [RQ21]
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Low-time counter; a quiet start already had one low clock from the peripheral
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 3'h0;
		end else if (state_reg == ST_IDLE) begin
			cnt_reg <= mode_quiet_reg ? ext_eff - 3'h1 : ext_eff; // [RQ10] [RQ12]
		end else if (state_reg == ST_FRAME) begin
			cnt_reg <= ctrl_quiet_reg ? STOP_QUIET_LEN - 3'h1 : STOP_CONT_LEN - 3'h1; // [RQ20]
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_reg <= 2'h0;
			frame_no_reg <= 6'h00;
		end else if (state_reg == ST_START_LOW) begin
			phase_reg <= 2'h1;
			frame_no_reg <= 6'h00;
		end else if (state_reg == ST_START_HIGH || state_reg == ST_FRAME) begin
			phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1; // [RQ14]
			if (sampling) begin
				frame_no_reg <= fn;
			end
		end
	end

	// Mode changes only at the end of a stop frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_quiet_reg <= 1'b0;
			mode_quiet_reg <= 1'b0; // [RQ13]
		end else begin
			if (state_reg == ST_FRAME) begin
				stop_quiet_reg <= ctrl_quiet_reg;
			end
			if (state_reg == ST_STOP_HIGH) begin
				mode_quiet_reg <= stop_quiet_reg; // [RQ13]
			end
		end
	end

	// Frame decode; frame one, channel check and spare frames are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ser_irq_reg <= 16'h0000;
			ser_pci_reg <= 4'h0;
			mgmt_reg <= 1'b0;
			mgmt_n_reg <= 1'b1;
		end else if (sampling) begin
			if (fn == FR_MGMT) begin
				mgmt_reg <= !serial_irq_line_i; // [RQ18]
				mgmt_n_reg <= serial_irq_line_i; // [RQ18]
			end else if (fn >= FR_IRQ_FIRST && fn <= FR_IRQ_LAST) begin
				ser_irq_reg[4'(fn - 6'h01)] <= !serial_irq_line_i; // [RQ16] [RQ17]
			end else if (fn >= FR_PCI_FIRST && fn <= FR_PCI_LAST) begin
				ser_pci_reg[2'(fn - FR_PCI_FIRST)] <= !serial_irq_line_i; // [RQ16]
			end
		end
	end

	// Drive only low, plus the one-clock high restore; never during data frames
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			oe_reg <= state_next inside {ST_START_LOW, ST_START_HIGH, ST_STOP_LOW,
				ST_STOP_HIGH}; // [RQ7] [RQ19]
			out_reg <= state_next inside {ST_START_HIGH, ST_STOP_HIGH}; // [RQ11]
		end
	end

	assign serial_irq_line_o = out_reg;
	assign serial_irq_line_oe_o = oe_reg;
	assign irq_o = irq_reg;
	assign external_mgmt_irq_out_n_o = mgmt_n_reg;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [3:0] low_run;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_run <= 4'h0;
		end else begin
			low_run <= (oe_reg && !out_reg) ? low_run + 4'h1 : 4'h0;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_stop_edge;
		state_reg == ST_STOP_HIGH;
	endsequence

	sequence s_release_gap;
		!oe_reg ##1 state_reg == ST_IDLE;
	endsequence

	reset_cont_a: assert property ($past(rst_i) |-> !mode_quiet_reg) // [RQ13]
		else $error("mode not continuous after reset");
	mode_change_a: assert property ($changed(mode_quiet_reg) |-> $past(state_reg == ST_STOP_HIGH)) // [RQ13]
		else $error("mode changed outside stop frame");
	start_len_a: assert property (state_reg == ST_START_HIGH |->
		low_run == (mode_quiet_reg ? {1'b0, ext_eff} : {1'b0, ext_eff} + 4'h1)) // [RQ10] [RQ12]
		else $error("start frame low length wrong");
	start_high_a: assert property (state_reg == ST_START_HIGH |-> oe_reg && out_reg ##1 !oe_reg) // [RQ11]
		else $error("start frame high clock wrong");
	stop_len_a: assert property (s_stop_edge |->
		low_run == (stop_quiet_reg ? 4'h2 : 4'h3) ##1 s_release_gap) // [RQ20] [RQ21]
		else $error("stop frame length or gap wrong");
	no_data_drive_a: assert property (state_reg == ST_FRAME |-> !oe_reg) // [RQ19]
		else $error("host drove a data frame");
	irq_zero_a: assert property (ser_irq_reg[0] == 1'b0 && ser_irq_reg[2] == 1'b0) // [RQ17]
		else $error("frame one or management slot reached irq vector");
	mgmt_out_a: assert property (sampling && fn == FR_MGMT && !serial_irq_line_i |=>
		!external_mgmt_irq_out_n_o) // [RQ18]
		else $error("management output not asserted");
	route_level_a: assert property (!pci_sync_n[0] && route_reg[0] == 8'h05 |=> irq_o[5]) // [RQ6]
		else $error("steered line not seen on input 5");
	legacy_or_a: assert property (legacy_irq_i[9] |=> irq_o[9]) // [RQ22]
		else $error("legacy input not passed through");

endmodule : pci_irq_steering_serial_irq_host

// ### verif/sirq_peripheral.sv
/*
 Behavioural peripheral on the serial interrupt line.
 Assumes the bench resolves the line with a pull-up and feeds it back.
*/
`timescale 1ns/100ps
module sirq_peripheral (
	input wire logic clk_i,
	input wire logic line_i,
	input wire logic start_i,
	input wire logic [31:0] frames_i,
	output logic pull_o
);
	int low_run = 0;
	int pos = 0;
	logic hit;
	initial pull_o = 1'b0;
	// The bench clock never stops, so a clock run request is never needed
	always @(posedge clk_i) begin
		if (pos != 0 && pos < 64) begin
			pos = pos + 1;
		end else begin
			pos = 0;
		end
		// Only a start frame stays low four clocks or more
		if (line_i && low_run >= 4) begin
			pos = 1;
		end
		low_run = line_i ? 0 : low_run + 1;
		hit = pos >= 2 && (pos - 2) % 3 == 0 && frames_i[(pos - 2) / 3 + 1];
		// Pull low only: in a sample phase, or for a one clock start pulse
		pull_o <= start_i || hit;
	end
endmodule : sirq_peripheral

// ### verif/pci_irq_steering_serial_irq_host_tb.sv
/*
 Self-checking bench for interrupt steering and the serial interrupt host.
 Assumes the design package and the peripheral model are compiled first.
*/
`timescale 1ns/100ps
module pci_irq_steering_serial_irq_host_tb
	import irq_front_pkg::*;
;
	typedef struct {
		logic [31:0] rt;
		logic [3:0] pn;
		logic [15:0] lg;
		logic [15:0] ex;
	} row_s;
	row_s rows [10] = '{
		'{32'h80808003, 4'he, 16'h0, 16'h0008}, '{32'h8080800f, 4'he, 16'h0, 16'h8000},
		'{32'h80808008, 4'he, 16'h0, 16'h0000}, '{32'h80808083, 4'he, 16'h0, 16'h0000},
		'{32'h80800505, 4'hc, 16'h0, 16'h0020}, '{32'h80800505, 4'hd, 16'h0, 16'h0020},
		'{32'h0e0b0a09, 4'h0, 16'h0, 16'h4e00}, '{32'h02070604, 4'h0, 16'h0, 16'h00d0},
		'{32'h8080800c, 4'hf, 16'h2, 16'h0002}, '{32'h0d010000, 4'h0, 16'h0, 16'h0000}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] pci_n = 4'hf;
	logic [15:0] legacy = 16'h0;
	logic start = 1'b0;
	logic [31:0] frames = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] q;
	logic [15:0] irq_o;
	logic wb_ack_o;
	logic sirq_o;
	logic sirq_oe;
	logic pull;
	logic mgmt_n;
	int fail_count = 0;
	int n_checks = 0;
	int cur = 0;
	int idle = 0;
	int gap_cur = 0;
	int runs [$];
	int gaps [$];
	// Open collector wire: any low drive wins over the pull-up
	wire logic sirq_wire = !((sirq_oe && !sirq_o) || pull);

	always #25 clk_i = !clk_i;

	pci_irq_steering_serial_irq_host pci_irq_steering_serial_irq_host_i (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pci_irq_lines_a_to_d_n_i(pci_n), .legacy_irq_i(legacy), .serial_irq_line_i(sirq_wire),
		.serial_irq_line_o(sirq_o), .serial_irq_line_oe_o(sirq_oe), .irq_o(irq_o),
		.external_mgmt_irq_out_n_o(mgmt_n));
	sirq_peripheral sirq_peripheral_i (.clk_i(clk_i), .line_i(sirq_wire), .start_i(start),
		.frames_i(frames), .pull_o(pull));

	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (wb_ack_o !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t: no bus answer", $time);
		end
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	// Expects a device start run of s, then a stop run of p after 64 released clocks
	task pair(input int s, input int p, input int n, input logic pls);
		int k;
		k = 0;
		runs.delete();
		gaps.delete();
		if (pls) begin
			start <= 1'b1;
			@(posedge clk_i);
			start <= 1'b0;
		end
		while (runs.size() < n && k < 400) begin
			@(posedge clk_i);
			k++;
			// Drop runs cut by the queue reset or made under an older setting
			while (runs.size() > 0 && runs[0] != s) begin
				void'(runs.pop_front());
				void'(gaps.pop_front());
			end
		end
		check(runs[0], s);
		check(runs[1], p);
		check(gaps[1], 64);
	endtask : pair

	////////////////////////////////////////////////////////////////////////////////
	// Length of each device low run and the released clocks before it
	always @(posedge clk_i) begin
		if (rst_i) begin
			cur = 0;
			idle = 0;
		end else if (sirq_oe && !sirq_o) begin
			if (cur == 0) begin
				gap_cur = idle;
			end
			cur++;
			idle = 0;
		end else begin
			if (cur != 0) begin
				runs.push_back(cur);
				gaps.push_back(gap_cur);
				check(sirq_oe & sirq_o, 1'b1);
			end
			cur = 0;
			if (!sirq_oe) begin
				idle++;
			end
		end
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(irq_o, 16'h0);
		check(mgmt_n, 1'b1);
		for (int j = 0; j < 4; j++) begin
			wb(1'b0, ROUTE_A_OFS + 8'(4 * j), 32'h0);
			check(q, {24'h0, ROUTE_RST});
		end
		wb(1'b0, SIRQ_CTRL_OFS, 32'h0);
		check(q, 32'h1507);
		wb(1'b1, 8'h20, 32'hffffffff);
		wb(1'b0, 8'h20, 32'h0);
		check(q, 32'h0);
		wb(1'b1, ROUTE_B_OFS, 32'hffffff83);
		wb(1'b0, ROUTE_B_OFS, 32'h0);
		check(q, 32'h83);
		pair(4, 3, 3, 1'b0);
		for (int i = 0; i < 10; i++) begin
			for (int j = 0; j < 4; j++) begin
				wb(1'b1, ROUTE_A_OFS + 8'(4 * j), {24'h0, rows[i].rt[8 * j +: 8]});
			end
			pci_n <= rows[i].pn;
			legacy <= rows[i].lg;
			repeat (6) @(posedge clk_i);
			check(irq_o, rows[i].ex);
		end
		pci_n <= 4'hf;
		legacy <= 16'h0;
		wb(1'b1, SIRQ_CTRL_OFS, 32'h150f);
		pair(8, 3, 3, 1'b0);
		// Quiet is reached only through a two clock stop, then the host stays silent
		wb(1'b1, SIRQ_CTRL_OFS, 32'h1517);
		repeat (200) @(posedge clk_i);
		check(runs[$], 2);
		runs.delete();
		repeat (100) @(posedge clk_i);
		check(runs.size(), 0);
		wb(1'b1, ROUTE_A_OFS, 32'h0b);
		frames <= 32'h0006010e;
		pair(3, 2, 2, 1'b1);
		repeat (4) @(posedge clk_i);
		check(irq_o, 16'h0882);
		check(mgmt_n, 1'b0);
		wb(1'b0, SIRQ_STAT_OFS, 32'h0);
		check(q, 32'h00310082);
		frames <= 32'h0;
		pair(3, 2, 2, 1'b1);
		repeat (4) @(posedge clk_i);
		check(irq_o, 16'h0);
		check(mgmt_n, 1'b1);
		complete_run();
	end
endmodule : pci_irq_steering_serial_irq_host_tb
